// File: core/ssp_pkg.sv
// Purpose: Shared constants, types and helpers of the synchronous serial port.
// Assumes: One clock, 32-bit classic Wishbone register access.
// Notes: Data width is held as a code equal to bits minus one.
// Summary of operation
// [R1] Transmit pushes keep only the low N configured bits of the write value.
// [R2] A push into a full transmit FIFO is refused and reported as not written.
// [R3] Receive and transmit DMA request enables are separate bits.
// [R4] Software programs the DMA channel before relying on the request enables.
// [R5] Four interrupt sources, each with its own enable bit.
// [R6] The interrupt line follows only enabled pending sources.
// [R7] Timeout and overrun flags clear individually or together by a clear write.
// [R8] Software clears a latched source early in its handler.
// [R9] Raw pending state and masked view are both readable.
// [R10] Configure before enabling; clearing the enable halts serial operation.
// [R11] Data width is configurable from 4 to 16 bits.
// [R12] Received entries carry valid data only in the low N bits.
// [R13] Busy holds until the transmit FIFO is empty and the last bit has left.
// [R14] Reading an empty receive FIFO returns nothing and keeps the pointers.
package ssp_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_RAW = 8'h10;
  localparam logic [7:0] OFS_MSKD = 8'h14;
  localparam logic [7:0] OFS_DMA = 8'h18;
  // Control fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WID_LSB = 4;
  localparam int CTRL_DIV_LSB = 8;
  // Status fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_TXFULL = 1;
  localparam int STAT_TXEMPTY = 2;
  localparam int STAT_RXEMPTY = 3;
  localparam int STAT_PUSHOK = 4;
  localparam int STAT_POPOK = 5;
  // Interrupt bit positions, shared by raw, mask and masked registers.
  localparam int IRQ_TXS = 0;
  localparam int IRQ_RXS = 1;
  localparam int IRQ_RTO = 2;
  localparam int IRQ_ROR = 3;
  localparam int DMA_RX_BIT = 0;
  localparam int DMA_TX_BIT = 1;
  // Reset values.
  localparam logic [3:0] WCODE_RST = 4'h7;
  localparam logic [7:0] DIV_RST = 8'h03;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Width codes for 4 and 16 bits.
  localparam logic [3:0] WCODE_MIN = 4'h3;
  localparam logic [3:0] WCODE_MAX = 4'hF;
  // Receive timeout in half bit periods of idle link with data waiting.
  localparam logic [6:0] RX_TIMEOUT_TICKS = 7'h40;
  localparam int FIFO_DEPTH = 8;

  // Serial pins driven by the port.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } link_out_t;
  localparam link_out_t LINK_IDLE = '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};

  // Codes below the minimum width are raised to it.
  function automatic logic [3:0] width_clamp(input logic [3:0] f);
    return (f < WCODE_MIN) ? WCODE_MIN : f;
  endfunction : width_clamp

  // Mask of the valid low bits for a width code.
  function automatic logic [15:0] width_mask(input logic [3:0] wc);
    return 16'hFFFF >> (WCODE_MAX - width_clamp(wc));
  endfunction : width_mask
endpackage : ssp_pkg

// File: core/ssp_fifo.sv
// Purpose: Synchronous show-ahead FIFO for one direction of the port.
// Assumes: Push into full and pop from empty are ignored.
// Notes: Pointers carry one extra bit to tell full from empty.
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic push, // Write one entry.
  input wire logic [W-1:0] wdata, // Entry to write.
  input wire logic pop, // Drop the head entry.
  output logic [W-1:0] rdata, // Head entry.
  output logic full, // No room left.
  output logic empty, // Nothing stored.
  output logic [AW:0] count // Entries stored.
);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } fifo_state_t;
  fifo_state_t s_reg, s_next;
  logic [W-1:0] mem [DEPTH];
  logic do_push, do_pop;

  // Flags are derived from the pointers so they never drift from the storage.
  assign count = s_reg.wptr - s_reg.rptr;
  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign rdata = mem[s_reg.rptr[AW-1:0]];
  assign do_push = push && !full;
  assign do_pop = pop && !empty; // R14

  // Pointer advance.
  always_comb
  begin
    s_next = s_reg;
    if (do_push)
    begin
      s_next.wptr = s_reg.wptr + 1'b1;
    end
    if (do_pop)
    begin
      s_next.rptr = s_reg.rptr + 1'b1;
    end
  end

  // Storage holds no reset; only written slots are ever read.
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[s_reg.wptr[AW-1:0]] <= wdata;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule : ssp_fifo
`default_nettype wire

// File: core/ssp_shifter.sv
// Purpose: Master shift engine, clock idle low, data changes on falling edge.
// Assumes: miso is already synchronised to clk.
// Notes: One word per chip select frame, MSB first.
`timescale 1ns/1ps
`default_nettype none
module ssp_shifter (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic en, // Port enable.
  input wire logic [3:0] wcode, // Width code, bits minus one.
  input wire logic [7:0] div, // Half bit period minus one, in clocks.
  input wire logic tx_valid, // A word waits.
  input wire logic [15:0] tx_data, // Word to send.
  output logic tx_ready, // Word taken this cycle when valid.
  input wire logic miso, // Synchronised serial input.
  output logic rx_valid, // One-cycle pulse with a received word.
  output logic [15:0] rx_data, // Received word, low bits valid.
  output logic busy, // Frame in progress.
  output logic tick, // Half bit period pulse.
  output ssp_pkg::link_out_t link // Serial pins.
);
  typedef enum logic [0:0] {SH_IDLE = 1'b0, SH_XFER = 1'b1} shift_state_t;
  typedef struct packed {
    shift_state_t state;
    logic [7:0] div_cnt;
    logic [15:0] sh;
    logic [15:0] rbuf;
    logic [4:0] bits;
    logic rx_valid;
    logic [15:0] rx_data;
    ssp_pkg::link_out_t link;
  } shift_reg_t;
  shift_reg_t s_reg, s_next;
  logic [3:0] wc;
  logic [15:0] aligned;

  assign wc = ssp_pkg::width_clamp(wcode);
  assign aligned = tx_data << (ssp_pkg::WCODE_MAX - wc);
  assign tick = (s_reg.div_cnt == div);
  assign tx_ready = en && (s_reg.state == SH_IDLE);
  assign busy = (s_reg.state == SH_XFER);
  assign rx_valid = s_reg.rx_valid;
  assign rx_data = s_reg.rx_data;
  assign link = s_reg.link;

  // Sample on rising edges, shift on falling; the frame ends with the last fall, in the same cycle.
  always_comb
  begin
    s_next = s_reg;
    s_next.rx_valid = 1'b0;
    s_next.div_cnt = tick ? 8'h00 : s_reg.div_cnt + 8'h01;
    if (!en)
    begin
      s_next.state = SH_IDLE; // R10
      s_next.link = ssp_pkg::LINK_IDLE;
    end
    else
    begin
      case (s_reg.state)
        SH_IDLE:
        begin
          if (tx_valid)
          begin
            s_next.state = SH_XFER;
            s_next.sh = aligned;
            s_next.bits = 5'h00;
            s_next.div_cnt = 8'h00;
            s_next.link = '{sclk: 1'b0, mosi: aligned[15], cs_n: 1'b0};
          end
        end
        SH_XFER:
        begin
          if (tick && !s_reg.link.sclk)
          begin
            s_next.link.sclk = 1'b1;
            s_next.rbuf = {s_reg.rbuf[14:0], miso};
            s_next.bits = s_reg.bits + 5'h01;
          end
          else if (tick)
          begin
            s_next.link.sclk = 1'b0;
            if (s_reg.bits == {1'b0, wc} + 5'h01)
            begin
              s_next.state = SH_IDLE;
              s_next.link.cs_n = 1'b1;
              s_next.rx_valid = 1'b1;
              s_next.rx_data = s_reg.rbuf & ssp_pkg::width_mask(wc); // R12
            end
            else
            begin
              s_next.sh = s_reg.sh << 1;
              s_next.link.mosi = s_reg.sh[14];
            end
          end
        end
        default:
        begin
          s_next.state = SH_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '{state: SH_IDLE, link: ssp_pkg::LINK_IDLE, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule : ssp_shifter
`default_nettype wire

// File: core/ssp_top.sv
// Purpose: Serial port with FIFOs, interrupts, DMA requests and a Wishbone slave.
// Assumes: Classic Wishbone, 32-bit data, byte addresses, one clock MCLK.
// Notes: Every access is answered one cycle after it is presented.
`timescale 1ns/1ps
`default_nettype none
module ssp_top #(
  parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
  input wire logic MCLK, // Clock, 125 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic CYC_I, // Wishbone cycle.
  input wire logic STB_I, // Wishbone strobe.
  input wire logic WE_I, // Wishbone write.
  input wire logic [7:0] ADR_I, // Wishbone byte address.
  input wire logic [3:0] SEL_I, // Wishbone byte enables.
  input wire logic [31:0] DAT_I, // Wishbone write data.
  output logic [31:0] DAT_O, // Wishbone read data.
  output logic ACK_O, // Wishbone acknowledge.
  output logic IRQ, // Interrupt, active high level.
  output logic TX_DMA_REQ, // Transmit DMA request.
  output logic RX_DMA_REQ, // Receive DMA request.
  output logic SCLK, // Serial clock.
  output logic MOSI, // Serial data out.
  output logic CS_N, // Chip select, active low.
  input wire logic MISO // Serial data in.
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
  localparam logic [6:0] RX_TIMEOUT_TICKS_M1 = ssp_pkg::RX_TIMEOUT_TICKS - 7'h01;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic en;
    logic [3:0] wcode;
    logic [7:0] div;
    logic [3:0] mask;
    logic [3:0] raw;
    logic [1:0] dma;
    logic push_ok;
    logic pop_ok;
    logic miso_s1;
    logic miso_s2;
    logic [6:0] to_cnt;
    logic irq;
    logic txreq;
    logic rxreq;
  } top_state_t;
  top_state_t s_reg, s_next;

  logic acc, wr, rd, tx_push, rx_pop, tx_full, tx_empty, rx_full, rx_empty;
  logic sh_ready, sh_valid, sh_busy, tick, busy;
  logic [15:0] tx_head, rx_head, sh_rx, tx_wdata, wmask;
  logic [AW:0] tx_count, rx_count;
  logic [3:0] ev, clr, mskd;
  logic [31:0] ctrl_word, ctrl_new;
  ssp_pkg::link_out_t link;

  // Byte-lane merge for writable registers.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Bus decode helpers; a request is taken when ack is generated.
  assign acc = CYC_I && STB_I && !s_reg.ack;
  assign wr = acc && WE_I;
  assign rd = acc && !WE_I;
  assign wmask = ssp_pkg::width_mask(s_reg.wcode);
  assign tx_wdata = DAT_I[15:0] & wmask; // R1
  assign tx_push = wr && (ADR_I == ssp_pkg::OFS_DATA) && SEL_I[0] && !tx_full; // R2
  assign rx_pop = rd && (ADR_I == ssp_pkg::OFS_DATA) && !rx_empty; // R14
  assign busy = !tx_empty || sh_busy; // R13
  assign mskd = s_reg.raw & s_reg.mask; // R9
  assign clr = (wr && (ADR_I == ssp_pkg::OFS_RAW) && SEL_I[0]) ? DAT_I[3:0] : 4'h0; // R7
  assign ctrl_word = {16'h0000, s_reg.div, s_reg.wcode, 3'h0, s_reg.en};
  // Control word as a write would leave it; only used when the control register is hit.
  assign ctrl_new = lane_merge(ctrl_word, DAT_I, SEL_I);

  // Event sources; the service events follow FIFO levels around half depth.
  always_comb
  begin
    ev = 4'h0;
    ev[ssp_pkg::IRQ_TXS] = s_reg.en && (tx_count <= HALF); // R5
    ev[ssp_pkg::IRQ_RXS] = (rx_count >= HALF); // R5
    ev[ssp_pkg::IRQ_ROR] = sh_valid && rx_full; // R5
    ev[ssp_pkg::IRQ_RTO] = tick && !rx_empty && !sh_busy && !rx_pop &&
                           (s_reg.to_cnt == RX_TIMEOUT_TICKS_M1); // R5
  end

  // Next state of the register file, bus answer and status.
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = acc;
    s_next.miso_s1 = MISO;
    s_next.miso_s2 = s_reg.miso_s1;
    if (wr)
    begin
      if (ADR_I == ssp_pkg::OFS_CTRL)
      begin
        s_next.en = ctrl_new[ssp_pkg::CTRL_EN_BIT];
        s_next.wcode = ssp_pkg::width_clamp(
          ctrl_new[ssp_pkg::CTRL_WID_LSB +: 4]); // R11
        s_next.div = ctrl_new[ssp_pkg::CTRL_DIV_LSB +: 8];
      end
      else if (ADR_I == ssp_pkg::OFS_DATA)
      begin
        s_next.push_ok = tx_push; // R2
      end
      else if (ADR_I == ssp_pkg::OFS_MASK && SEL_I[0])
      begin
        s_next.mask = DAT_I[3:0]; // R5
      end
      else if (ADR_I == ssp_pkg::OFS_DMA && SEL_I[0])
      begin
        s_next.dma = DAT_I[1:0]; // R3
      end
    end
    if (rd)
    begin
      s_next.rdata = 32'h0000_0000;
      if (ADR_I == ssp_pkg::OFS_CTRL)
      begin
        s_next.rdata = ctrl_word;
      end
      else if (ADR_I == ssp_pkg::OFS_DATA)
      begin
        s_next.rdata = rx_empty ? 32'h0000_0000 : {16'h0000, rx_head}; // R14
        s_next.pop_ok = !rx_empty;
      end
      else if (ADR_I == ssp_pkg::OFS_STAT)
      begin
        s_next.rdata[ssp_pkg::STAT_BUSY] = busy; // R13
        s_next.rdata[ssp_pkg::STAT_TXFULL] = tx_full;
        s_next.rdata[ssp_pkg::STAT_TXEMPTY] = tx_empty;
        s_next.rdata[ssp_pkg::STAT_RXEMPTY] = rx_empty;
        s_next.rdata[ssp_pkg::STAT_PUSHOK] = s_reg.push_ok;
        s_next.rdata[ssp_pkg::STAT_POPOK] = s_reg.pop_ok;
      end
      else if (ADR_I == ssp_pkg::OFS_MASK)
      begin
        s_next.rdata[3:0] = s_reg.mask;
      end
      else if (ADR_I == ssp_pkg::OFS_RAW)
      begin
        s_next.rdata[3:0] = s_reg.raw; // R9
      end
      else if (ADR_I == ssp_pkg::OFS_MSKD)
      begin
        s_next.rdata[3:0] = mskd; // R9
      end
      else if (ADR_I == ssp_pkg::OFS_DMA)
      begin
        s_next.rdata[1:0] = s_reg.dma;
      end
    end
    // A new event wins over a clear in the same cycle.
    s_next.raw = (s_reg.raw & ~clr) | ev; // R7
    // Timeout restarts on any link or receive FIFO activity and is held while that FIFO is empty.
    if (rx_empty || rx_pop || sh_valid || sh_busy)
    begin
      s_next.to_cnt = 7'h00;
    end
    else if (tick && s_reg.to_cnt != ssp_pkg::RX_TIMEOUT_TICKS)
    begin
      s_next.to_cnt = s_reg.to_cnt + 7'h01;
    end
    s_next.irq = |(s_next.raw & s_next.mask); // R6
    s_next.txreq = s_next.dma[ssp_pkg::DMA_TX_BIT] && !tx_full; // R3
    s_next.rxreq = s_next.dma[ssp_pkg::DMA_RX_BIT] && !rx_empty; // R3
  end

  // State register; everything takes a constant at reset.
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s_reg <= '{wcode: ssp_pkg::WCODE_RST, div: ssp_pkg::DIV_RST,
                 mask: ssp_pkg::MASK_RST, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops.
  assign DAT_O = s_reg.rdata;
  assign ACK_O = s_reg.ack;
  assign IRQ = s_reg.irq;
  assign TX_DMA_REQ = s_reg.txreq;
  assign RX_DMA_REQ = s_reg.rxreq;
  assign SCLK = link.sclk;
  assign MOSI = link.mosi;
  assign CS_N = link.cs_n;

  // Transmit FIFO, written from the bus and drained by the shifter.
  ssp_fifo #(.W(16), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(MCLK),
    .rst_b(RST_B),
    .push(tx_push),
    .wdata(tx_wdata),
    .pop(sh_ready && !tx_empty),
    .rdata(tx_head),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );

  // Receive FIFO; a word arriving when full is dropped and flagged.
  ssp_fifo #(.W(16), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(MCLK),
    .rst_b(RST_B),
    .push(sh_valid),
    .wdata(sh_rx),
    .pop(rx_pop),
    .rdata(rx_head),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );

  // Shift engine on the synchronised serial input.
  ssp_shifter u_shifter (
    .clk(MCLK),
    .rst_b(RST_B),
    .en(s_reg.en),
    .wcode(s_reg.wcode),
    .div(s_reg.div),
    .tx_valid(!tx_empty),
    .tx_data(tx_head),
    .tx_ready(sh_ready),
    .miso(s_reg.miso_s2),
    .rx_valid(sh_valid),
    .rx_data(sh_rx),
    .busy(sh_busy),
    .tick(tick),
    .link(link)
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // Bus, flag and request checks; each but the two ack checks names the rule that it guards.
  AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property ((CYC_I && STB_I && !ACK_O) |=> ACK_O)
    else $error("request not answered in one cycle");
  AST_TX_TRUNC: assert property (tx_push |-> (tx_wdata & ~wmask) == 16'h0000) // R1
    else $error("bits above the width reached the transmit FIFO");
  AST_FULL_REFUSED: assert property ((wr && ADR_I == ssp_pkg::OFS_DATA && tx_full) // R2
    |=> !s_reg.push_ok)
    else $error("push into full FIFO reported as written");
  AST_DMA_GATED: assert property ((TX_DMA_REQ |-> s_reg.dma[ssp_pkg::DMA_TX_BIT]) // R3
    and (RX_DMA_REQ |-> s_reg.dma[ssp_pkg::DMA_RX_BIT]))
    else $error("DMA request without its enable");
  AST_IRQ_MASKED: assert property (IRQ == |(s_reg.raw & s_reg.mask)) // R6
    else $error("interrupt line disagrees with enabled pending sources");
  AST_OVERRUN_SET: assert property ((sh_valid && rx_full) |=> s_reg.raw[ssp_pkg::IRQ_ROR]) // R7
    else $error("overrun not flagged");
  AST_CLEAR_ROR: assert property ((clr[ssp_pkg::IRQ_ROR] && !ev[ssp_pkg::IRQ_ROR]) // R7
    |=> !s_reg.raw[ssp_pkg::IRQ_ROR])
    else $error("overrun flag survived its clear");
  AST_MASKED_READ: assert property ((rd && ADR_I == ssp_pkg::OFS_MSKD) // R9
    |=> DAT_O[3:0] == $past(mskd))
    else $error("masked view differs from raw and enables");
  AST_BUSY_WIRE: assert property ((!CS_N || !tx_empty) |-> busy) // R13
    else $error("not busy while a word is in flight");
  AST_RX_WIDTH: assert property (sh_valid |-> (sh_rx & ~wmask) == 16'h0000) // R12
    else $error("received word has bits above the width");
  AST_EMPTY_POP: assert property ((rd && ADR_I == ssp_pkg::OFS_DATA && rx_empty && !sh_valid)
    |=> (DAT_O == 32'h0000_0000) && rx_empty) // R14
    else $error("empty receive read changed the FIFO");
  AST_CLEAR_RTO: assert property ((clr[ssp_pkg::IRQ_RTO] && !ev[ssp_pkg::IRQ_RTO]) // R7
    |=> !s_reg.raw[ssp_pkg::IRQ_RTO])
    else $error("timeout flag survived its clear");
  AST_DMA_LEVEL: assert property ( // R3
    (TX_DMA_REQ == (s_reg.dma[ssp_pkg::DMA_TX_BIT] && $past(!tx_full))) &&
    (RX_DMA_REQ == (s_reg.dma[ssp_pkg::DMA_RX_BIT] && $past(!rx_empty))))
    else $error("DMA request does not follow its enable and FIFO level");
  AST_PUSH_OK: assert property (tx_push |=> s_reg.push_ok && !tx_empty) // R2
    else $error("accepted push not reported or not stored");

  // Main scenarios that the bench is expected to reach.
  COV_REFUSED: cover property (wr && ADR_I == ssp_pkg::OFS_DATA && tx_full);
  COV_DMA_BOTH: cover property (TX_DMA_REQ && RX_DMA_REQ);
  COV_OVERRUN: cover property (sh_valid && rx_full);
  COV_TIMEOUT: cover property (ev[ssp_pkg::IRQ_RTO]);
  COV_IRQ: cover property ($rose(IRQ));
endmodule : ssp_top
`default_nettype wire

// File: verification/spi_peer.sv
// Purpose: Serial slave peer that answers the port's frames.
// Assumes: Clock idle low, sample on rise, change on fall, MSB first.
// Notes: While deselected MISO shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
  input wire logic sclk, // Serial clock from the port.
  input wire logic mosi, // Data from the port.
  input wire logic cs_n, // Select, active low.
  input wire logic [15:0] reply, // Base answer, xored with the frame count.
  input wire logic [4:0] nbits, // Bits per frame.
  output var logic miso, // Data to the port.
  output var int done // Frames finished.
);
  logic [15:0] word;
  logic [15:0] got;
  logic [15:0] got_q[$];
  int cnt;
  initial
  begin
    miso = 1'b0;
    done = 0;
    cnt = 0;
    got = 16'h0000;
  end
  // A frame loads its answer and shows the first bit before any clock edge.
  always @(negedge cs_n)
  begin
    word = reply ^ 16'(done);
    cnt = 0;
    miso = word[nbits - 1];
  end
  // Capture on the rising edge, present the next bit on the falling edge.
  always @(posedge sclk)
    if (!cs_n)
    begin
      got = {got[14:0], mosi};
      cnt = cnt + 1;
    end
  always @(negedge sclk)
    if (!cs_n && cnt < nbits)
      miso = word[nbits - 1 - cnt];
  // Empty selects, such as the one at reset, store nothing.
  always @(posedge cs_n)
    if (cnt > 0)
    begin
      got_q.push_back(got & ((16'h0001 << nbits) - 16'h0001));
      done = done + 1;
      cnt = 0;
      miso = ~miso;
    end
endmodule : spi_peer
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench of the serial port through its register bus.
// Assumes: One clock; the peer answers every frame.
// Notes: FIFO depth is reduced to 4 so fill and overrun stay short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEPTH = 4;
  localparam logic [7:0] ZOFS[6] = '{ssp_pkg::OFS_MASK, ssp_pkg::OFS_RAW, ssp_pkg::OFS_MSKD,
    ssp_pkg::OFS_DMA, ssp_pkg::OFS_DATA, 8'h20};
  logic mclk, rst_b, cyc, stb, we, ack, irq, tx_dma, rx_dma, sclk, mosi, cs_n, miso;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, rdat;
  logic [15:0] reply;
  logic [4:0] nbits;
  logic [15:0] txq[$], rxq[$];
  int n_errors, compares, seed, peer_done;
  ssp_top #(.DEPTH(DEPTH)) dut_u (.MCLK(mclk), .RST_B(rst_b), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .IRQ(irq), .TX_DMA_REQ(tx_dma), .RX_DMA_REQ(rx_dma), .SCLK(sclk), .MOSI(mosi),
    .CS_N(cs_n), .MISO(miso));
  spi_peer peer_u (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .reply(reply), .nbits(nbits),
    .miso(miso), .done(peer_done));
  // Compare and count; unknowns never match.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // One classic cycle; held until the edge that samples ack, released after it.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (ack !== 1'b1 && i < 100);
    chk("ack", 32'(ack), 32'h1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic irq_is(input logic e);
    @(negedge mclk);
    chk("irq", 32'(irq), 32'(e));
  endtask : irq_is
  task automatic pop_chk;
    wb(1'b0, ssp_pkg::OFS_DATA, 32'h0);
    chk("rx_word", rdat, 32'(rxq.pop_front()));
  endtask : pop_chk
  task automatic wait_frames(input int n);
    int i;
    i = 0;
    while (peer_done < n && i < 5000)
    begin
      @(posedge mclk);
      i++;
    end
    chk("frames", 32'(peer_done), 32'(n));
  endtask : wait_frames
  // One width: fill, refuse, send, overrun, interrupts, DMA, drain.
  task automatic pass(input logic [3:0] wc);
    logic [15:0] m;
    logic [31:0] ctrl;
    int base;
    m = 16'hFFFF >> (4'hF - wc);
    ctrl = {16'h0000, ssp_pkg::DIV_RST, wc, 4'h0};
    nbits = {1'b0, wc} + 5'h01;
    reply = 16'($random(seed));
    base = peer_done;
    wb(1'b1, ssp_pkg::OFS_CTRL, ctrl);
    wb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", rdat, ctrl);
    for (int i = 0; i <= DEPTH; i++)
    begin
      wb(1'b1, ssp_pkg::OFS_DATA, $random(seed));
      if (i < DEPTH)
        txq.push_back(dat[15:0] & m);
      wb(1'b0, ssp_pkg::OFS_STAT, 32'h0);
      chk("push_ok", 32'(rdat[ssp_pkg::STAT_PUSHOK]), 32'(i < DEPTH));
    end
    chk("tx_full", 32'(rdat[ssp_pkg::STAT_TXFULL]), 32'h1);
    wb(1'b1, ssp_pkg::OFS_CTRL, ctrl | 32'h1);
    wb(1'b0, ssp_pkg::OFS_STAT, 32'h0);
    chk("busy", 32'(rdat[ssp_pkg::STAT_BUSY]), 32'h1);
    wait_frames(base + DEPTH);
    for (int k = 0; k < DEPTH; k++)
      rxq.push_back((reply ^ 16'(base + k)) & m);
    // The reply to this word arrives with the receive side full and is dropped.
    wb(1'b1, ssp_pkg::OFS_DATA, $random(seed));
    txq.push_back(dat[15:0] & m);
    wait_frames(base + DEPTH + 1);
    repeat (400) @(posedge mclk);
    wb(1'b0, ssp_pkg::OFS_STAT, 32'h0);
    chk("idle", 32'(rdat[2:0]), 32'h4);
    while (peer_u.got_q.size() > 0)
      chk("mosi_word", 32'(peer_u.got_q.pop_front()), 32'(txq.pop_front()));
    wb(1'b0, ssp_pkg::OFS_RAW, 32'h0);
    chk("raw_all", rdat, 32'hF);
    wb(1'b1, ssp_pkg::OFS_MASK, 32'h0);
    irq_is(1'b0);
    wb(1'b1, ssp_pkg::OFS_MASK, 32'hC);
    wb(1'b0, ssp_pkg::OFS_MSKD, 32'h0);
    chk("masked", rdat, 32'hC);
    irq_is(1'b1);
    // Clear early, one flag at a time; the pop restarts the timeout count, which the drain then holds at zero.
    wb(1'b1, ssp_pkg::OFS_RAW, 32'h8);
    wb(1'b0, ssp_pkg::OFS_RAW, 32'h0);
    chk("clr_overrun", rdat, 32'h7);
    pop_chk();
    wb(1'b1, ssp_pkg::OFS_RAW, 32'h4);
    wb(1'b0, ssp_pkg::OFS_RAW, 32'h0);
    chk("clr_timeout", rdat, 32'h3);
    irq_is(1'b0);
    wb(1'b1, ssp_pkg::OFS_MASK, 32'hF);
    wb(1'b0, ssp_pkg::OFS_MSKD, 32'h0);
    chk("masked_svc", rdat, 32'h3);
    irq_is(1'b1);
    for (int v = 0; v < 4; v++)
    begin
      wb(1'b1, ssp_pkg::OFS_DMA, 32'(v));
      @(negedge mclk);
      chk("dma_req", {30'h0, tx_dma, rx_dma}, 32'(v));
    end
    wb(1'b1, ssp_pkg::OFS_DMA, 32'h0);
    while (rxq.size() > 0)
      pop_chk();
    wb(1'b0, ssp_pkg::OFS_DATA, 32'h0);
    chk("empty_read", rdat, 32'h0);
    wb(1'b0, ssp_pkg::OFS_STAT, 32'h0);
    chk("pop_ok", 32'(rdat[ssp_pkg::STAT_POPOK]), 32'h0);
    wb(1'b1, ssp_pkg::OFS_CTRL, ctrl);
    wb(1'b1, ssp_pkg::OFS_RAW, 32'hF);
    wb(1'b0, ssp_pkg::OFS_RAW, 32'h0);
    chk("raw_clear", rdat, 32'h0);
  endtask : pass
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // A hang counts as a mismatch and ends the run the normal way.
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_sim();
  end
  // An unmapped write, then reset values, the width floor, then both width limits.
  initial
  begin
    seed = 32'h55a5549d;
    n_errors = 0;
    compares = 0;
    rst_b = 1'b0;
    {cyc, stb, we} = 3'b000;
    adr = 8'h00;
    dat = 32'h0;
    reply = 16'h0000;
    nbits = 5'h08;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
    chk("ctrl_rst", rdat, {16'h0, ssp_pkg::DIV_RST, ssp_pkg::WCODE_RST, 4'h0});
    wb(1'b0, ssp_pkg::OFS_STAT, 32'h0);
    chk("stat_rst", rdat & 32'hF, 32'hC);
    foreach (ZOFS[j])
    begin
      wb(1'b0, ZOFS[j], 32'h0);
      chk("zero_reg", rdat, 32'h0);
    end
    wb(1'b1, ssp_pkg::OFS_CTRL, 32'h0);
    wb(1'b0, ssp_pkg::OFS_CTRL, 32'h0);
    chk("ctrl_floor", rdat, {16'h0, 8'h00, ssp_pkg::WCODE_MIN, 4'h0});
    pass(ssp_pkg::WCODE_MIN);
    pass(ssp_pkg::WCODE_MAX);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
